// [logic/rotl_pkg.sv]
package rotl_pkg;
	localparam logic [11:0] ADDR_WDOG_CTRL     = 12'h03C;
	localparam logic [11:0] ADDR_TEMP_TRIM     = 12'h040;
	localparam logic [11:0] ADDR_ACLK_TRIM     = 12'h044;
	localparam logic [11:0] ADDR_OSC_TRIM      = 12'h048;
	localparam logic [11:0] ADDR_BANDGAP_REF   = 12'h04C;
	localparam logic [11:0] ADDR_ROUTE_CTRL    = 12'h050;
	localparam logic [11:0] ADDR_OSC_CTRL      = 12'h054;
	localparam logic [11:0] ADDR_LOAD_STATUS   = 12'h058;
	localparam logic [17:0] FADDR_OPTION_BYTE  = 18'h3FF0E;
	localparam logic [17:0] FADDR_BANDGAP      = 18'h0405A;
	localparam logic [17:0] FADDR_TRIM_A       = 18'h040B8;
	localparam logic [17:0] FADDR_TRIM_B       = 18'h040BA;
	localparam int          WIN_BIT            = 3;
	localparam int          ACLK_LSB           = 10;
	localparam int          HTTR_LSB           = 2;
	localparam int          TCT_LSB            = 10;
	localparam logic [3:0]  CH_BANDGAP_TEMP    = 4'h1;
	localparam logic [3:0]  CH_FLASH_SUPPLY    = 4'h2;
	localparam logic [3:0]  CH_BATT_SENSE      = 4'hA;
	localparam logic [3:0]  CH_HV_PORTL        = 4'hB;
	localparam logic [2:0]  SEL_NONE           = 3'h0;
	localparam logic [2:0]  SEL_BANDGAP_TEMP   = 3'h1;
	localparam logic [2:0]  SEL_FLASH_SUPPLY   = 3'h2;
	localparam logic [2:0]  SEL_BATT_SENSE     = 3'h3;
	localparam logic [2:0]  SEL_HV_PORTL       = 3'h4;
	typedef enum logic [2:0] {
		LD_OPTION, LD_TRIM_A, LD_TRIM_B, LD_BANDGAP, LD_DONE
	} rotl_state_e;
endpackage : rotl_pkg

// [logic/rotl_loader.sv]
// Operation
// R1: Each reset copies watchdog rate and window bits from flash option byte.
// R2: Rate is inverse of option bits 2:0; window is inverse of bit 3.
// R3: Temperature trim gets family default from flash; software calibrates.
// R4: Word 0x40B8 gives clock and temp trim; 0x40BA oscillator trims.
// R5: Factory bandgap conversion readable from info row bytes at 0x405A.
// R6: Larger variant: trigger zero from port P pin 0, one from pin 1.
// R7: Triggers two and three unconnected; never produce events.
// R8: Larger variant option routes triggers to port S pins 2 and 3.
// R9: Smaller variant: triggers fixed on port S pins 2 and 3.
// R10: Special channel codes select bandgap, flash supply, battery, port L.
// R11: Oscillator swing, monitor reset enable, PLL flag only on later mask.
// R12: Periodic timer clock output drives port S pin 2 when enabled.
// R13: CPU held in reset until all flash configuration is loaded.
// R14: Trim fields loaded in same reset sequence as watchdog bits.
module rotl_loader
	import rotl_pkg::*;
#(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter bit LATE_MASK     = 1'b1
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [17:0] flash_addr,
	output logic             flash_rd,
	input  wire logic [15:0] flash_data,
	input  wire logic        flash_valid,
	output logic             cpu_hold,
	output logic      [2:0]  watchdog_rate_select,
	output logic             watchdog_window_mode,
	output logic      [3:0]  temp_sensor_trim,
	output logic      [5:0]  autonomous_clock_trim,
	output logic      [4:0]  osc_tempco_trim,
	output logic      [9:0]  osc_frequency_trim,
	output logic             osc_full_swing_select,
	output logic             osc_monitor_reset_enable,
	input  wire logic        pll_monitor_fault,
	input  wire logic        portp_pin_zero,
	input  wire logic        portp_pin_one,
	input  wire logic        ports_pin_two,
	input  wire logic        ports_pin_three,
	output logic             conv_trigger_zero,
	output logic             conv_trigger_one,
	output logic             conv_trigger_two,
	output logic             conv_trigger_three,
	input  wire logic        special_channel_select,
	input  wire logic [3:0]  channel_code,
	output logic      [2:0]  special_source,
	input  wire logic        periodic_timer_clk,
	output logic             ports_pin_two_out,
	output logic             ports_pin_two_oe
);
	rotl_state_e  state_r;
	logic [7:0]   wctrl_r;
	logic [15:0]  bandgap_r;
	logic [1:0]   route_r;
	logic [1:0]   oscctl_r;
	logic         pll_flag_r;
	logic [3:0]   pins_s1_r;
	logic [3:0]   pins_s2_r;
	logic [1:0]   ptclk_s1_r;
	logic [1:0]   ptclk_s2_r;
	logic         wr_en;
	logic         rd_en;
	logic         loaded;
	logic [31:0]  rd_word;

	assign loaded  = (state_r == LD_DONE);
	assign wr_en   = psel && penable && pwrite && loaded;
	assign rd_en   = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// Flash load sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= LD_OPTION;
		end else if (flash_valid) begin
			case (state_r)
				LD_OPTION:  state_r <= LD_TRIM_A; // R1 R14
				LD_TRIM_A:  state_r <= LD_TRIM_B; // R14
				LD_TRIM_B:  state_r <= LD_BANDGAP;
				LD_BANDGAP: state_r <= LD_DONE;
				LD_DONE:    state_r <= LD_DONE;
				default:    state_r <= LD_OPTION;
			endcase
		end
	end

	always_comb begin
		flash_rd = !loaded;
		case (state_r)
			LD_OPTION:  flash_addr = FADDR_OPTION_BYTE;
			LD_TRIM_A:  flash_addr = FADDR_TRIM_A; // R4
			LD_TRIM_B:  flash_addr = FADDR_TRIM_B; // R4
			LD_BANDGAP: flash_addr = FADDR_BANDGAP; // R5
			default:    flash_addr = FADDR_OPTION_BYTE;
		endcase
	end

	assign cpu_hold = !loaded; // R13

	// Watchdog control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wctrl_r <= 8'h00;
		end else if (state_r == LD_OPTION && flash_valid) begin
			wctrl_r[2:0]     <= ~flash_data[2:0]; // R1 R2
			wctrl_r[WIN_BIT] <= ~flash_data[WIN_BIT]; // R2
		end else if (wr_en && paddr == ADDR_WDOG_CTRL) begin
			wctrl_r <= pwdata[7:0];
		end
	end
	assign watchdog_rate_select = wctrl_r[2:0];
	assign watchdog_window_mode = wctrl_r[WIN_BIT];

	// Info row trims
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			temp_sensor_trim <= 4'h0;
		end else if (state_r == LD_TRIM_A && flash_valid) begin
			temp_sensor_trim <= flash_data[HTTR_LSB +: 4]; // R3 R14
		end else if (wr_en && paddr == ADDR_TEMP_TRIM) begin
			temp_sensor_trim <= pwdata[3:0]; // R3
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			autonomous_clock_trim <= 6'h00;
		end else if (state_r == LD_TRIM_A && flash_valid) begin
			autonomous_clock_trim <= flash_data[ACLK_LSB +: 6]; // R4
		end else if (wr_en && paddr == ADDR_ACLK_TRIM) begin
			autonomous_clock_trim <= pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_tempco_trim <= 5'h00;
		end else if (state_r == LD_TRIM_B && flash_valid) begin
			osc_tempco_trim <= flash_data[TCT_LSB +: 5]; // R4 R14
		end else if (wr_en && paddr == ADDR_OSC_TRIM) begin
			osc_tempco_trim <= pwdata[TCT_LSB +: 5];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_frequency_trim <= 10'h000;
		end else if (state_r == LD_TRIM_B && flash_valid) begin
			osc_frequency_trim <= flash_data[9:0]; // R4
		end else if (wr_en && paddr == ADDR_OSC_TRIM) begin
			osc_frequency_trim <= pwdata[9:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bandgap_r <= 16'h0000;
		end else if (state_r == LD_BANDGAP && flash_valid) begin
			bandgap_r <= flash_data; // R5
		end
	end

	// Routing and oscillator control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			route_r <= 2'h0;
		end else if (wr_en && paddr == ADDR_ROUTE_CTRL) begin
			route_r <= pwdata[1:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oscctl_r <= 2'h0;
		end else if (wr_en && paddr == ADDR_OSC_CTRL && LATE_MASK) begin
			oscctl_r <= pwdata[1:0]; // R11
		end
	end
	assign osc_full_swing_select    = LATE_MASK && oscctl_r[0]; // R11
	assign osc_monitor_reset_enable = LATE_MASK && oscctl_r[1]; // R11

	// PLL monitor flag, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_flag_r <= 1'b0;
		end else if (!LATE_MASK) begin
			pll_flag_r <= 1'b0; // R11
		end else if (pll_monitor_fault) begin
			pll_flag_r <= 1'b1;
		end else if (wr_en && paddr == ADDR_OSC_CTRL && pwdata[8]) begin
			pll_flag_r <= 1'b0;
		end
	end

	// Pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_s1_r  <= 4'h0;
			pins_s2_r  <= 4'h0;
			ptclk_s1_r <= 2'h0;
			ptclk_s2_r <= 2'h0;
		end else begin
			pins_s1_r  <= {ports_pin_three, ports_pin_two,
				portp_pin_one, portp_pin_zero};
			pins_s2_r  <= pins_s1_r;
			ptclk_s1_r <= {route_r[1], periodic_timer_clk};
			ptclk_s2_r <= ptclk_s1_r;
		end
	end

	// Converter trigger routing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_trigger_zero <= 1'b0;
			conv_trigger_one  <= 1'b0;
		end else if (!LARGE_VARIANT || route_r[0]) begin
			conv_trigger_zero <= pins_s2_r[2]; // R8 R9
			conv_trigger_one  <= pins_s2_r[3]; // R8 R9
		end else begin
			conv_trigger_zero <= pins_s2_r[0]; // R6
			conv_trigger_one  <= pins_s2_r[1]; // R6
		end
	end
	assign conv_trigger_two   = 1'b0; // R7
	assign conv_trigger_three = 1'b0; // R7

	// Special channel decode
	always_comb begin
		special_source = SEL_NONE;
		if (special_channel_select) begin
			case (channel_code)
				CH_BANDGAP_TEMP: special_source = SEL_BANDGAP_TEMP; // R10
				CH_FLASH_SUPPLY: special_source = SEL_FLASH_SUPPLY; // R10
				CH_BATT_SENSE:   special_source = SEL_BATT_SENSE; // R10
				CH_HV_PORTL:     special_source = SEL_HV_PORTL; // R10
				default:         special_source = SEL_NONE;
			endcase
		end
	end

	// Periodic timer clock out on port S pin 2
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ports_pin_two_out <= 1'b0;
			ports_pin_two_oe  <= 1'b0;
		end else begin
			ports_pin_two_out <= ptclk_s2_r[0] && route_r[1]; // R12
			ports_pin_two_oe  <= route_r[1]; // R12
		end
	end

	// Register read mux
	always_comb begin
		rd_word = 32'h0000_0000;
		case (paddr)
			ADDR_WDOG_CTRL: begin
				rd_word[7:0] = wctrl_r;
			end
			ADDR_TEMP_TRIM: begin
				rd_word[3:0] = temp_sensor_trim;
			end
			ADDR_ACLK_TRIM: begin
				rd_word[5:0] = autonomous_clock_trim;
			end
			ADDR_OSC_TRIM: begin
				rd_word[TCT_LSB +: 5] = osc_tempco_trim;
				rd_word[9:0]          = osc_frequency_trim;
			end
			ADDR_BANDGAP_REF: begin
				rd_word[15:0] = bandgap_r; // R5
			end
			ADDR_ROUTE_CTRL: begin
				rd_word[1:0] = route_r;
			end
			ADDR_OSC_CTRL: begin
				rd_word[8]   = pll_flag_r; // R11
				rd_word[1:0] = oscctl_r; // R11
			end
			ADDR_LOAD_STATUS: begin
				rd_word[0] = loaded;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Latched in setup phase so it stands at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_word;
		end
	end
endmodule : rotl_loader

// [verification/rotl_props.sv]
module rotl_props
	import rotl_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [17:0] flash_addr,
	input wire logic        flash_rd,
	input wire logic [15:0] flash_data,
	input wire logic        flash_valid,
	input wire logic        cpu_hold,
	input wire logic [2:0]  watchdog_rate_select,
	input wire logic        watchdog_window_mode,
	input wire logic [5:0]  autonomous_clock_trim,
	input wire logic [9:0]  osc_frequency_trim,
	input wire logic        conv_trigger_two,
	input wire logic        conv_trigger_three,
	input wire logic        special_channel_select,
	input wire logic [3:0]  channel_code,
	input wire logic [2:0]  special_source
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Flash word taken at a given address
	sequence s_take(logic [17:0] a);
		flash_valid && flash_addr == a;
	endsequence
	a_rate_inverse: assert property (
		s_take(FADDR_OPTION_BYTE) |=>
		watchdog_rate_select == ~$past(flash_data[2:0]))
		else $error("rate select not inverse of option bits");
	a_window_inverse: assert property (
		s_take(FADDR_OPTION_BYTE) |=>
		watchdog_window_mode == !$past(flash_data[WIN_BIT]))
		else $error("window mode not inverse of option bit");
	a_trim_a_load: assert property (
		s_take(FADDR_TRIM_A) |=>
		autonomous_clock_trim == $past(flash_data[15:10]))
		else $error("clock trim not loaded");
	a_trim_b_load: assert property (
		s_take(FADDR_TRIM_B) |=>
		osc_frequency_trim == $past(flash_data[9:0]))
		else $error("frequency trim not loaded");
	a_load_order: assert property (
		s_take(FADDR_OPTION_BYTE) |=> flash_addr == FADDR_TRIM_A)
		else $error("load order broken");
	a_hold_release: assert property (
		s_take(FADDR_BANDGAP) |=> !cpu_hold[*2])
		else $error("cpu hold not released after load");
	a_hold_reads: assert property (cpu_hold |-> flash_rd)
		else $error("cpu held without flash read");
	a_hold_cause: assert property ($fell(cpu_hold) |->
		$past(flash_valid)) else $error("hold fell without load");
	a_trig_unused: assert property (
		!conv_trigger_two && !conv_trigger_three)
		else $error("unused trigger active");
	a_chan_portl: assert property (
		special_channel_select && channel_code == CH_HV_PORTL |->
		special_source == SEL_HV_PORTL) else $error("port L channel");
endmodule : rotl_props

bind rotl_loader rotl_props u_props (.pclk, .presetn, .flash_addr,
	.flash_rd, .flash_data, .flash_valid, .cpu_hold,
	.watchdog_rate_select, .watchdog_window_mode, .autonomous_clock_trim,
	.osc_frequency_trim, .conv_trigger_two, .conv_trigger_three,
	.special_channel_select, .channel_code, .special_source);

// [verification/rotl_flash_model.sv]
module rotl_flash_model
	import rotl_pkg::*;
#(
	parameter logic [15:0] TA = 16'h0000,
	parameter logic [15:0] TB = 16'h0000,
	parameter logic [15:0] BG = 16'h0000
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [3:0]  dly,
	input wire logic [15:0] opt,
	input wire logic [17:0] addr,
	input wire logic        rd,
	output logic     [15:0] data,
	output logic            valid
);
	logic [3:0] cnt_r;
	// Word answered after dly idle cycles; data flips when not valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 4'h0;
			valid <= 1'b0;
			data  <= 16'h5A5A;
		end else begin
			valid <= 1'b0;
			data  <= ~data;
			if (rd && !valid && cnt_r == dly) begin
				cnt_r <= 4'h0;
				valid <= 1'b1;
				case (addr)
					FADDR_OPTION_BYTE: data <= opt;
					FADDR_TRIM_A:      data <= TA;
					FADDR_TRIM_B:      data <= TB;
					FADDR_BANDGAP:     data <= BG;
					default:           data <= 16'hDEAD;
				endcase
			end else if (rd && !valid) begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule : rotl_flash_model

// [verification/rotl_tb.sv]
module rotl_tb
	import rotl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] TA = 16'hA5B4;
	localparam logic [15:0] TB = 16'h6DC3;
	localparam logic [15:0] BG = 16'h0321;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [17:0] flash_addr;
	logic [15:0] flash_data, opt;
	logic        flash_rd, flash_valid, cpu_hold, watchdog_window_mode;
	logic [2:0]  watchdog_rate_select, special_source;
	logic [3:0]  temp_sensor_trim, channel_code, dly;
	logic [5:0]  autonomous_clock_trim;
	logic [4:0]  osc_tempco_trim;
	logic [9:0]  osc_frequency_trim;
	logic        osc_full_swing_select, osc_monitor_reset_enable;
	logic        pll_monitor_fault, special_channel_select;
	logic        portp_pin_zero, portp_pin_one, ports_pin_two, ports_pin_three;
	logic        conv_trigger_zero, conv_trigger_one;
	logic        conv_trigger_two, conv_trigger_three;
	logic        periodic_timer_clk, ports_pin_two_out, ports_pin_two_oe;
	int          err_count, tests_run;
	logic [31:0] rd_data;
	wire  [3:0]  trig = {conv_trigger_three, conv_trigger_two,
		conv_trigger_one, conv_trigger_zero};
	localparam logic [3:0] CODES [4] = '{CH_BANDGAP_TEMP, CH_FLASH_SUPPLY,
		CH_BATT_SENSE, CH_HV_PORTL};
	localparam logic [2:0] SELS [4] = '{SEL_BANDGAP_TEMP, SEL_FLASH_SUPPLY,
		SEL_BATT_SENSE, SEL_HV_PORTL};

	rotl_loader dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_rd,
		.flash_data, .flash_valid, .cpu_hold, .watchdog_rate_select,
		.watchdog_window_mode, .temp_sensor_trim, .autonomous_clock_trim,
		.osc_tempco_trim, .osc_frequency_trim, .osc_full_swing_select,
		.osc_monitor_reset_enable, .pll_monitor_fault, .portp_pin_zero,
		.portp_pin_one, .ports_pin_two, .ports_pin_three, .conv_trigger_zero,
		.conv_trigger_one, .conv_trigger_two, .conv_trigger_three,
		.special_channel_select, .channel_code, .special_source,
		.periodic_timer_clk, .ports_pin_two_out, .ports_pin_two_oe);
	rotl_flash_model #(.TA(TA), .TB(TB), .BG(BG)) u_flash (.clk(pclk),
		.rst_n(presetn), .dly, .opt, .addr(flash_addr), .rd(flash_rd),
		.data(flash_data), .valid(flash_valid));

	task stop_test;
		$display("tests_run=%0d err_count=%0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Read data is taken at the access edge
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task do_reset(input logic [3:0] d, input logic [15:0] o);
		presetn <= 1'b0;
		dly     <= d;
		opt     <= o;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(cpu_hold, 1'b1);
		while (cpu_hold !== 1'b0) @(posedge pclk);
		chk(watchdog_rate_select, {~o[2:0]});
		chk(watchdog_window_mode, {~o[3]});
		chk({autonomous_clock_trim, temp_sensor_trim},
			{TA[15:10], TA[5:2]});
		chk({osc_tempco_trim, osc_frequency_trim}, TB[14:0]);
		xfer(1'b0, ADDR_BANDGAP_REF, 32'h0, rd_data);
		chk(rd_data, {16'h0, BG});
	endtask : do_reset

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		stop_test();
	end
	initial begin
		{psel, penable, pwrite, pll_monitor_fault, special_channel_select} = '0;
		{portp_pin_zero, portp_pin_one, ports_pin_two, ports_pin_three} = '0;
		{presetn, periodic_timer_clk, paddr, pwdata, channel_code} = '0;
		{dly, opt} = '0;
		for (int i = 0; i < 16; i++) do_reset(4'(i % 4), 16'hFFF0 | 16'(i));
		xfer(1'b1, ADDR_WDOG_CTRL, 32'h6, rd_data);
		xfer(1'b0, ADDR_WDOG_CTRL, 32'h0, rd_data);
		chk(rd_data, 32'h6);
		chk({watchdog_window_mode, watchdog_rate_select}, 4'h6);
		xfer(1'b0, 12'h0FC, 32'h0, rd_data);
		chk(rd_data, 32'h0);
		portp_pin_zero <= 1'b1;
		ports_pin_three <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(trig, 4'b0001);
		xfer(1'b1, ADDR_ROUTE_CTRL, 32'h1, rd_data);
		repeat (4) @(posedge pclk);
		chk(trig, 4'b0010);
		xfer(1'b1, ADDR_ROUTE_CTRL, 32'h2, rd_data);
		periodic_timer_clk <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({ports_pin_two_oe, ports_pin_two_out}, 2'b11);
		periodic_timer_clk <= 1'b0;
		repeat (4) @(posedge pclk);
		chk({ports_pin_two_oe, ports_pin_two_out}, 2'b10);
		for (int i = 0; i < 4; i++) begin
			special_channel_select <= 1'b1;
			channel_code <= CODES[i];
			@(posedge pclk);
			chk(special_source, SELS[i]);
		end
		xfer(1'b1, ADDR_OSC_CTRL, 32'h3, rd_data);
		chk({osc_monitor_reset_enable, osc_full_swing_select}, 2'b11);
		pll_monitor_fault <= 1'b1;
		@(posedge pclk);
		pll_monitor_fault <= 1'b0;
		xfer(1'b0, ADDR_OSC_CTRL, 32'h0, rd_data);
		chk(rd_data, 32'h103);
		stop_test();
	end
endmodule : rotl_tb
